// ---- rtl/pwil_defs.vh ----
`ifndef PWIL_DEFS_VH
`define PWIL_DEFS_VH

// interleave/frequency register layout
`define PWIL_INT_PHASE_MSB 4
`define PWIL_INT_PHASE_LSB 0
`define PWIL_INT_FREQ_MSB 7
`define PWIL_INT_FREQ_LSB 5
`define PWIL_INT_RESET 8'h00

// duty limit register layout
`define PWIL_LIM_CEIL_MSB 7
`define PWIL_LIM_CEIL_LSB 2
`define PWIL_LIM_HSAT_BIT 1
`define PWIL_LIM_LSAT_BIT 0
`define PWIL_LIM_RESET 8'hE0

// phase step is 1/32 of a turn (11.25 degrees)
`define PWIL_PHASE_STEPS 32
`define PWIL_DUTY_STEPS 64

// register selects on the write port
`define PWIL_SEL_INT 4'h0
`define PWIL_SEL_LIM 4'h1
`define PWIL_SEL_NUM0_HIGH 4'h2
`define PWIL_SEL_NUM0_LOW 4'h3
`define PWIL_SEL_NUM1_HIGH 4'h4
`define PWIL_SEL_NUM1_LOW 4'h5
`define PWIL_SEL_NUM2_HIGH 4'h6
`define PWIL_SEL_NUM2_LOW 4'h7
`define PWIL_SEL_NUM3_HIGH 4'h8
`define PWIL_SEL_NUM3_LOW 4'h9
`define PWIL_SEL_DEN1 4'hA
`define PWIL_SEL_DEN2 4'hB
`define PWIL_SEL_DEN3 4'hC

`endif

// ---- rtl/pwil_core.v ----
`timescale 1ns/1ps
`default_nettype none
`include "pwil_defs.vh"

// Notes on behaviour
// R01: pwm on-time starts the programmed phase after each sync clock rising edge.
// R02: phase programmable in 11.25 degree steps, independent of converter count.
// R03: five-bit phase code maps linearly, 00h is 0, 1Fh is 348.75 degrees.
// R04: interleave register accepts writes only while the converter output is off.
// R05: controller should avoid 112.5 and 123.75 degree phase settings.
// R06: duty capped by six-bit ceiling in bits 7:2, code n gives n/64.
// R07: inside saturation window duty follows the filter proportionally to error.
// R08: outside window with saturation enabled, duty jumps to limit or zero in one cycle.
// R09: bit 1 enables high-side saturation, bit 0 low-side; 1 enables.
// R10: controller keeps saturation off above 2.0 V, limit 120-140 percent.
// R11: compensation is a third-order filter, integrator pole plus two poles, two zeros.
// R12: four split numerator and three denominator coefficients held in registers.
// R13: ceiling zero suppresses on-time; output never exceeds the ceiling; a pulse running or starting as it drops keeps its old length.
module pwil_core #(
  parameter ERR_W = 12,
  parameter COEF_W = 16,
  parameter SAT_WIN = 12'd256,
  parameter PER_W = 12
) (
  input wire i_sys_clk,
  input wire i_reset,
  input wire i_sync_clock_line,
  input wire i_output_enabled,
  input wire i_wr_en,
  input wire [3:0] i_wr_sel,
  input wire [7:0] i_wr_data,
  input wire [3:0] i_rd_sel,
  output reg [7:0] o_rd_data,
  input wire signed [ERR_W-1:0] i_error,
  input wire i_error_valid,
  output reg o_pwm,
  output reg [5:0] o_duty_q
);
  reg [7:0] int_q;
  reg [7:0] lim_q;
  reg [7:0] coef_q [0:10];
  reg s1_q, s2_q, s3_q;
  reg [PER_W-1:0] cnt_q, per_q, ph_cnt_q, on_cnt_q;
  reg ph_run_q;
  reg signed [31:0] acc_q, y1_q, y2_q, y3_q, e1_q, e2_q, e3_q;
  reg signed [31:0] y_d;
  reg [5:0] duty_d;
  wire [5:0] ceil_w = lim_q[`PWIL_LIM_CEIL_MSB:`PWIL_LIM_CEIL_LSB];
  wire [4:0] phase_w = int_q[`PWIL_INT_PHASE_MSB:`PWIL_INT_PHASE_LSB];
  wire sync_rise = s2_q & ~s3_q;
  // window is symmetric around zero error; limitation: one width for both sides
  wire signed [ERR_W-1:0] win = SAT_WIN;
  wire signed [COEF_W-1:0] c0 = {coef_q[0], coef_q[1]};
  wire signed [COEF_W-1:0] c1 = {coef_q[2], coef_q[3]};
  wire signed [COEF_W-1:0] c2 = {coef_q[4], coef_q[5]};
  wire signed [COEF_W-1:0] c3 = {coef_q[6], coef_q[7]};
  wire signed [7:0] den1 = coef_q[8];
  wire signed [7:0] den2 = coef_q[9];
  wire signed [7:0] den3 = coef_q[10];
  // phase delay in clocks: period * code / 32
  wire [PER_W+4:0] ph_prod = per_q * phase_w;
  wire [PER_W-1:0] ph_dly = ph_prod[PER_W+4:5];
  wire [PER_W+5:0] on_prod = per_q * o_duty_q;
  wire [PER_W-1:0] on_len = on_prod[PER_W+5:6];
  // a lag near a full turn can meet the next sync edge:
  // fire the pending pulse then rather than drop it
  wire pwm_start = ph_run_q & (sync_rise | (ph_cnt_q == {PER_W{1'b0}}));
  integer k;

  // sync line is asynchronous: two flops before use
  always @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= i_sync_clock_line;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      int_q <= `PWIL_INT_RESET;
      lim_q <= `PWIL_LIM_RESET;
      for (k = 0; k < 11; k = k + 1) begin
        coef_q[k] <= 8'h00;
      end
    end else if (i_wr_en) begin
      case (i_wr_sel)
        // R04 write only while off
        `PWIL_SEL_INT: begin
          if (!i_output_enabled) begin
            int_q <= i_wr_data;
          end
        end
        // R06 R09 ceiling and saturation enables
        `PWIL_SEL_LIM: lim_q <= i_wr_data;
        default: begin
          // R12 coefficient bytes
          // bytes land one at a time: the filter runs on a half-written pair meanwhile
          if (i_wr_sel >= `PWIL_SEL_NUM0_HIGH && i_wr_sel <= `PWIL_SEL_DEN3) begin
            coef_q[i_wr_sel - `PWIL_SEL_NUM0_HIGH] <= i_wr_data;
          end
        end
      endcase
    end
  end

  always @* begin
    if (i_rd_sel == `PWIL_SEL_INT) begin
      o_rd_data = int_q;
    end else if (i_rd_sel == `PWIL_SEL_LIM) begin
      o_rd_data = lim_q;
    end else if (i_rd_sel >= `PWIL_SEL_NUM0_HIGH && i_rd_sel <= `PWIL_SEL_DEN3) begin
      o_rd_data = coef_q[i_rd_sel - `PWIL_SEL_NUM0_HIGH];
    end else begin
      // unmapped selects read as zero
      o_rd_data = 8'h00;
    end
  end

  // R11 direct-form third order filter, coefficients scaled by 2^-8
  always @* begin
    // limitation: 32-bit sums, large coefficients with full-scale error can wrap
    y_d = ((c0 * i_error) + (c1 * e1_q) + (c2 * e2_q) + (c3 * e3_q)
          - (den1 * y1_q) - (den2 * y2_q)
          - (den3 * y3_q)) >>> 8;
  end

  always @* begin
    duty_d = o_duty_q;
    // R08 R09 saturate outside window
    if (lim_q[`PWIL_LIM_HSAT_BIT] && i_error > win) begin
      duty_d = ceil_w;
    end else if (lim_q[`PWIL_LIM_LSAT_BIT] && i_error < -win) begin
      duty_d = 6'h00;
    // R07 proportional path, clamped
    end else if (acc_q < 0) begin
      duty_d = 6'h00;
    end else if (acc_q > {26'd0, ceil_w}) begin
      // R13 never above ceiling
      duty_d = ceil_w;
    end else begin
      duty_d = acc_q[5:0];
    end
    if (duty_d > ceil_w) begin
      duty_d = ceil_w;
    end
  end

  always @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      acc_q <= 32'sd0;
      y1_q <= 32'sd0;
      y2_q <= 32'sd0;
      y3_q <= 32'sd0;
      e1_q <= 32'sd0;
      e2_q <= 32'sd0;
      e3_q <= 32'sd0;
    end else if (i_error_valid) begin
      acc_q <= y_d;
      y1_q <= y_d;
      y2_q <= y1_q;
      y3_q <= y2_q;
      e1_q <= {{(32-ERR_W){i_error[ERR_W-1]}}, i_error};
      e2_q <= e1_q;
      e3_q <= e2_q;
    end
  end

  // period measured between sync edges; phase timer then on-time timer
  always @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      cnt_q <= {PER_W{1'b0}};
      per_q <= {PER_W{1'b0}};
      ph_cnt_q <= {PER_W{1'b0}};
      ph_run_q <= 1'b0;
      o_duty_q <= 6'h00;
    end else begin
      cnt_q <= sync_rise ? {PER_W{1'b0}} : cnt_q + 1'b1;
      if (sync_rise) begin
        per_q <= cnt_q + 1'b1;
        // R01 R02 R03 start phase delay
        ph_run_q <= 1'b1;
        ph_cnt_q <= ph_dly;
      end else if (ph_run_q) begin
        if (ph_cnt_q == {PER_W{1'b0}}) begin
          ph_run_q <= 1'b0;
        end else begin
          ph_cnt_q <= ph_cnt_q - 1'b1;
        end
      end
      if (sync_rise) begin
        // R08 duty takes effect next switching cycle
        o_duty_q <= duty_d;
      end else if (o_duty_q > ceil_w) begin
        // R13 a lowered ceiling applies at once, not at the next sync edge
        o_duty_q <= ceil_w;
      end
    end
  end

  // on-time timer runs apart from the phase timer, so a pulse that
  // straddles a sync edge still ends after its own length
  always @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      on_cnt_q <= {PER_W{1'b0}};
      o_pwm <= 1'b0;
    end else if (pwm_start) begin
      on_cnt_q <= on_len;
      // R13 zero ceiling or duty gives no on-time
      o_pwm <= (on_len != {PER_W{1'b0}});
    end else if (o_pwm) begin
      if (on_cnt_q <= {{(PER_W-1){1'b0}}, 1'b1}) begin
        o_pwm <= 1'b0;
      end
      on_cnt_q <= on_cnt_q - 1'b1;
    end
  end
endmodule

`default_nettype wire

// ---- verif/pwm_mgr_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module pwm_mgr_model (
  output var logic o_sync
);
  // master clock runs free, offset so it never lines up with the system clock
  initial begin
    o_sync = 1'b0;
    #1.3;
    forever #62.5 o_sync = ~o_sync;
  end
endmodule
`default_nettype wire

// ---- verif/pwil_core_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module pwil_chk (
  input wire i_sys_clk,
  input wire i_reset,
  input wire i_output_enabled,
  input wire i_wr_en,
  input wire [3:0] i_wr_sel,
  input wire [7:0] i_wr_data,
  input wire [3:0] i_rd_sel,
  input wire [7:0] o_rd_data,
  input wire o_pwm,
  input wire [5:0] o_duty_q
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  a_duty_within_ceiling: assert property (
    i_rd_sel == 4'h1 && $stable(o_rd_data) |-> o_duty_q <= o_rd_data[7:2])
    else $error("duty above ceiling");
  a_unmapped_reads_zero: assert property (
    i_rd_sel > 4'hC |-> o_rd_data == 8'h00) else $error("unmapped read not zero");
  a_limit_write_lands: assert property (
    i_wr_en && i_wr_sel == 4'h1 ##1 i_rd_sel == 4'h1 |-> o_rd_data == $past(i_wr_data))
    else $error("limit write lost");
  a_phase_locked_on: assert property (
    i_wr_en && i_wr_sel == 4'h0 && i_output_enabled && i_rd_sel == 4'h0
    ##1 i_rd_sel == 4'h0 |-> $stable(o_rd_data)) else $error("phase changed while on");
  a_pulse_needs_duty: assert property (
    $rose(o_pwm) |-> $past(o_duty_q) != 6'h00) else $error("pulse with zero duty");
  a_pulse_ends_soon: assert property (
    $rose(o_pwm) |-> ##[1:40] !o_pwm) else $error("pulse too long");
endmodule
bind pwil_core pwil_chk i_pwil_chk (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
  .i_output_enabled(i_output_enabled), .i_wr_en(i_wr_en), .i_wr_sel(i_wr_sel),
  .i_wr_data(i_wr_data), .i_rd_sel(i_rd_sel), .o_rd_data(o_rd_data), .o_pwm(o_pwm),
  .o_duty_q(o_duty_q));
`default_nettype wire

// ---- verif/pwm_interleave_duty_limit_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module pwm_interleave_duty_limit_tb;
  logic i_sys_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_output_enabled = 1'b1;
  logic i_wr_en = 1'b0;
  logic [3:0] i_wr_sel = 4'h0;
  logic [3:0] i_rd_sel = 4'h0;
  logic [7:0] i_wr_data = 8'h00;
  logic signed [11:0] i_error = 12'sh000;
  logic i_error_valid = 1'b0;
  wire sync;
  wire o_pwm;
  wire [7:0] o_rd_data;
  wire [5:0] o_duty_q;
  integer mismatches = 0;
  integer check_count = 0;
  integer d0, d, w;
  always #2 i_sys_clk = ~i_sys_clk;
  pwm_mgr_model i_pwm_mgr_model (.o_sync(sync));
  pwil_core i_pwil_core (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_sync_clock_line(sync),
    .i_output_enabled(i_output_enabled), .i_wr_en(i_wr_en), .i_wr_sel(i_wr_sel),
    .i_wr_data(i_wr_data), .i_rd_sel(i_rd_sel), .o_rd_data(o_rd_data), .i_error(i_error),
    .i_error_valid(i_error_valid), .o_pwm(o_pwm), .o_duty_q(o_duty_q));
  task wrap_up;
    $display("mismatches=%0d check_count=%0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task wr(input logic [3:0] s, input logic [7:0] v);
    @(negedge i_sys_clk);
    i_wr_en = 1'b1;
    i_wr_sel = s;
    i_wr_data = v;
    @(negedge i_sys_clk);
    i_wr_en = 1'b0;
  endtask
  task rd(input logic [3:0] s, input logic [7:0] e);
    @(negedge i_sys_clk);
    i_rd_sel = s;
    #1 check(o_rd_data, e);
  endtask
  task till(input bit p, input logic v, output integer n);
    n = 0;
    while ((p ? o_pwm : sync) !== v) begin
      @(negedge i_sys_clk);
      n++;
      if (n > 99) begin
        mismatches++;
        wrap_up;
      end
    end
  endtask
  // delay counts through any tail of the previous pulse
  task meas(output integer dl, output integer wd);
    integer n;
    till(0, 1'b0, n);
    till(0, 1'b1, n);
    till(1, 1'b0, dl);
    till(1, 1'b1, n);
    dl = dl + n;
    till(1, 1'b0, wd);
  endtask
  task quiet;
    integer h;
    h = 0;
    repeat (80) begin
      @(negedge i_sys_clk);
      h += (o_pwm !== 1'b0);
    end
    check(h[7:0], 8'h00);
    check({2'b00, o_duty_q}, 8'h00);
  endtask
  initial begin
    repeat (16) @(negedge i_sys_clk);
    i_reset = 1'b0;
    rd(4'h1, 8'hE0);
    rd(4'hF, 8'h00);
    rd(4'h0, 8'h00);
    wr(4'h0, 8'h10);
    rd(4'h0, 8'h00);
    i_error = 12'sh7FF;
    wr(4'h1, 8'h02);
    rd(4'h1, 8'h02);
    quiet;
    wr(4'h1, 8'h42);
    meas(d0, w);
    meas(d0, w);
    check({2'b00, o_duty_q}, 8'h10);
    check({7'h00, w >= 7 && w <= 8}, 8'h01);
    i_output_enabled = 1'b0;
    wr(4'h0, 8'h10);
    rd(4'h0, 8'h10);
    meas(d, w);
    meas(d, w);
    check({7'h00, d - d0 >= 14 && d - d0 <= 17}, 8'h01);
    wr(4'h0, 8'h1F);
    meas(d, w);
    meas(d, w);
    // lag of nearly a turn lands just before the next sync edge seen
    check({7'h00, d - d0 >= -4 && d - d0 <= 0}, 8'h01);
    wr(4'h1, 8'h40);
    repeat (80) @(negedge i_sys_clk);
    quiet;
    wr(4'h2, 8'h01);
    wr(4'h3, 8'h00);
    rd(4'h2, 8'h01);
    i_error = 12'sh005;
    @(negedge i_sys_clk);
    i_error_valid = 1'b1;
    @(negedge i_sys_clk);
    i_error_valid = 1'b0;
    repeat (80) @(negedge i_sys_clk);
    check({2'b00, o_duty_q}, 8'h05);
    wrap_up;
  end
endmodule
`default_nettype wire
